// [rtl/ssync_defs.svh]
// constants shared by both ends of the shunt sample synchronizer
// assumes it is included by bare name from the package and both ends
`ifndef SSYNC_DEFS_SVH
`define SSYNC_DEFS_SVH

// channel count and decimation figures
`define SS_CHANNELS 3
`define SS_FILTER_OSR 128
`define SS_INTEG_OSR 8
`define SS_EFFECTIVE_OVERSAMPLING_RATIO 1024
// sinc3 accumulator width: 1 + 3 * log2(128)
`define SS_ACC_W 22
// integrated sample width: accumulator plus log2(8)
`define SS_SAMPLE_W 25
// voltage converter resolution
`define SS_VOLT_W 14

// clock figures in hz
`define SS_CLK_HZ 20000000
`define SS_MOD_HZ_TARGET 6000000
`define SS_MOD_HZ_MIN 5000000
`define SS_MOD_HZ_MAX 20000000
// modulator clock half period in host clock cycles (20 mhz / 2 = 10 mhz)
`define SS_MOD_HALF 1

// spi and link housekeeping, in host clock cycles or modulator ticks
`define SS_SPI_HALF 16
`define SS_FRAME_GAP 64
`define SS_LINK_RESET_TICKS 16

`endif

// [rtl/ssync_pkg.sv]
// types shared by both ends of the shunt sample synchronizer
// assumes ssync_defs.svh is on the include path
package ssync_pkg;
  `include "ssync_defs.svh"

  // one integrated current sample
  typedef logic [`SS_SAMPLE_W-1:0] sample_type;

  // one voltage conversion result
  typedef logic [`SS_VOLT_W-1:0] volt_type;

  // host spi read sequencer
  typedef enum logic [2:0] {
    st_idle,
    st_lead,
    st_high,
    st_low,
    st_gap
  } host_state_type;
endpackage

// [rtl/ssync_if.sv]
// link between the host end and the filter device end
// assumes the testbench instantiates it once and joins both ends to it
`timescale 1ns/1ps
interface ssync_if;
  logic host_subsystem_clock_out; // modulator clock made by the host
  logic link_resetn; // reset held low for some modulator ticks
  logic sample_ready; // new sample set pending in the device
  logic spi_sclk; // spi clock, idle low
  logic spi_cs_n; // spi select, active low
  logic spi_miso; // spi data from device

  // host drives clock, reset and spi control
  modport host (
    output host_subsystem_clock_out,
    output link_resetn,
    output spi_sclk,
    output spi_cs_n,
    input sample_ready,
    input spi_miso
  );

  // device runs on the modulator clock
  modport device (
    input host_subsystem_clock_out,
    input link_resetn,
    input spi_sclk,
    input spi_cs_n,
    output sample_ready,
    output spi_miso
  );
endinterface // ssync_if

// [rtl/filter_device.sv]
// filter device end: clock forwarding, sinc3 decimation, integration, spi read-out
// assumes the modulator clock and link reset come from the host over ssync_if
//
// Contract
// - host supplies modulator clock into device
// - device forwards clock to three channel outputs
// - modulator clock stays between 5 and 20 mhz
// - bitstreams accepted only once clocks run
// - one filter channel per modulator
// - each channel decimates bitstream into samples
// - sample-ready raised for each new set
// - host reads samples over spi when alerted
// - host timer counts modulator clock to ratio
// - timer starts voltage conversions in hardware
// - one voltage sample per current sample
// - voltage converter is fourteen bits wide
// - effective ratio 1024 equals 128 times 8
// - ready only after integrator sums configured count
// - design modulator clock six megahertz nominal; the divider here gives 10 mhz (MOD_HALF 1 from the 20 mhz host clock)
`timescale 1ns/1ps
`include "ssync_defs.svh"
module filter_device
  import ssync_pkg::*;
#(
  parameter int CHANNELS = `SS_CHANNELS,
  parameter int FILTER_OSR = `SS_FILTER_OSR,
  parameter int INTEG_OSR = `SS_INTEG_OSR
) (
  // link to the host
  ssync_if.device link,
  // configuration
  input wire logic i_forward_enable,
  // modulator bitstreams, one per channel
  input wire logic [CHANNELS-1:0] i_bitstream,
  // forwarded modulator clocks and status
  output logic [CHANNELS-1:0] o_channel_clock_out,
  output logic o_clocks_running
);

  localparam int FW = $clog2(FILTER_OSR); // filter counter width
  localparam int IW = (INTEG_OSR > 1) ? $clog2(INTEG_OSR) : 1; // integrator counter width
  localparam int AW = `SS_ACC_W; // sinc3 accumulator width
  localparam int SW = `SS_SAMPLE_W; // integrated sample width
  localparam int FRAME_BITS = CHANNELS * SW; // bits per spi read
  localparam int BW = $clog2(FRAME_BITS + 1); // spi bit counter width
  localparam logic [FW-1:0] FILT_LAST = FW'(FILTER_OSR - 1); // last filter tick
  localparam logic [IW-1:0] INTEG_LAST = IW'(INTEG_OSR - 1); // last integrator tick
  localparam logic [BW-1:0] FRAME_LAST = BW'(FRAME_BITS); // full frame count

  // the whole device runs on the modulator clock
  wire modulator_clock_in = link.host_subsystem_clock_out;
  // host reset and configuration synchronizers
  logic resetn_meta, resetn_sync; // link reset synchronizer stages
  logic fwd_meta, fwd_sync; // forward enable synchronizer stages
  logic fwd_on; // forwarding state, reset low
  logic fwd_gate; // gate enable, moved on the falling edge
  logic run; // channels may take bits
  logic [CHANNELS-1:0] bit_meta, bit_sync; // bitstream synchronizer stages
  // shared decimation counters
  logic [FW-1:0] filt_count; // position inside one filter output
  logic [IW-1:0] integ_count; // filter outputs summed so far
  logic filt_tick; // filter output in this cycle
  logic set_ready; // integrated set complete in this cycle
  sample_type sample [CHANNELS]; // per channel results, last complete set

  // spi slave state
  logic sclk_meta, sclk_sync; // sclk synchronizer stages
  logic sclk_prev; // edge detect
  logic cs_meta, cs_sync; // select synchronizer stages
  logic cs_prev; // edge detect
  logic [FRAME_BITS-1:0] shift; // outgoing frame
  logic [FRAME_BITS-1:0] frame; // frame assembled from samples
  logic [BW-1:0] bit_count; // rising sclk edges seen
  logic ready; // sample-ready flag
  logic read_done; // full frame read and select released

  // two-flop reset synchronizer; reset itself carries no data path
  always_ff @(posedge modulator_clock_in) begin
    resetn_meta <= link.link_resetn;
    resetn_sync <= resetn_meta;
  end

  // two-flop synchronizer for the forward enable
  always_ff @(posedge modulator_clock_in) begin
    fwd_meta <= i_forward_enable;
    fwd_sync <= fwd_meta;
  end

  // forwarding state follows the synchronized enable
  always_ff @(posedge modulator_clock_in) begin
    if (!resetn_sync) begin
      fwd_on <= 1'b0;
    end else begin
      fwd_on <= fwd_sync;
    end
  end

  // gate enable changes while the clock is low, so no runt pulses
  always_ff @(negedge modulator_clock_in) begin
    if (!resetn_sync) begin
      fwd_gate <= 1'b0;
    end else begin
      fwd_gate <= fwd_on;
    end
  end

  // glitch-free gated copies of the modulator clock, one per channel
  assign o_channel_clock_out = {CHANNELS{modulator_clock_in & fwd_gate}};

  // status: clocks are being forwarded
  always_ff @(posedge modulator_clock_in) begin
    if (!resetn_sync) begin
      o_clocks_running <= 1'b0;
    end else begin
      o_clocks_running <= fwd_gate;
    end
  end

  // channels are held clear until the modulators see a clock
  assign run = resetn_sync & fwd_on & fwd_gate;

  // bitstream pins pass two flops before the filters
  always_ff @(posedge modulator_clock_in) begin
    bit_meta <= i_bitstream;
    bit_sync <= bit_meta;
  end

  // filter counter: one output every FILTER_OSR bits
  always_ff @(posedge modulator_clock_in) begin
    if (!run) begin
      filt_count <= '0;
    end else if (filt_tick) begin
      filt_count <= '0;
    end else begin
      filt_count <= filt_count + FW'(1);
    end
  end

  // integrator counter: one set every INTEG_OSR filter outputs
  always_ff @(posedge modulator_clock_in) begin
    if (!run) begin
      integ_count <= '0;
    end else if (filt_tick) begin
      if (integ_count == INTEG_LAST) begin
        integ_count <= '0;
      end else begin
        integ_count <= integ_count + IW'(1);
      end
    end
  end
  assign filt_tick = run && (filt_count == FILT_LAST);
  assign set_ready = filt_tick && (integ_count == INTEG_LAST);

  // one independent sinc3 plus integrator per modulator
  for (genvar g = 0; g < CHANNELS; g++) begin : g_chan
    logic [AW-1:0] acc1, acc2, acc3; // cascaded integrators
    logic [AW-1:0] dly1, dly2, dly3; // comb delays
    logic [AW-1:0] comb1, comb2, comb3; // comb outputs
    logic [SW-1:0] sum; // integrator unit running sum
    logic [SW-1:0] filt_ext; // filter output widened
    // comb section, evaluated at the decimated rate
    assign comb1 = acc3 - dly1;
    assign comb2 = comb1 - dly2;
    assign comb3 = comb2 - dly3;
    assign filt_ext = {{(SW - AW){1'b0}}, comb3};

    // modulator rate integrators; channel g takes only bitstream g
    always_ff @(posedge modulator_clock_in) begin
      if (!run) begin
        acc1 <= '0;
        acc2 <= '0;
        acc3 <= '0;
      end else begin
        acc1 <= acc1 + {{(AW - 1){1'b0}}, bit_sync[g]};
        acc2 <= acc2 + acc1;
        acc3 <= acc3 + acc2;
      end
    end

    // comb delays and integrator unit at each filter output
    always_ff @(posedge modulator_clock_in) begin
      if (!run) begin
        dly1 <= '0;
        dly2 <= '0;
        dly3 <= '0;
        sum <= '0;
        sample[g] <= '0;
      end else if (filt_tick) begin
        dly1 <= acc3;
        dly2 <= comb1;
        dly3 <= comb2;
        if (integ_count == INTEG_LAST) begin
          sample[g] <= sum + filt_ext;
          sum <= '0;
        end else begin
          sum <= sum + filt_ext;
        end
      end
    end
  end

  // frame layout: channel 0 first, each sample msb first
  always_comb begin
    frame = '0;
    for (int i = 0; i < CHANNELS; i++) begin
      frame[(CHANNELS - 1 - i) * SW +: SW] = sample[i];
    end
  end

  // spi pins from the host pass two flops
  always_ff @(posedge modulator_clock_in) begin
    sclk_meta <= link.spi_sclk;
    sclk_sync <= sclk_meta;
    cs_meta <= link.spi_cs_n;
    cs_sync <= cs_meta;
  end

  // edge history of the synchronized spi pins
  always_ff @(posedge modulator_clock_in) begin
    if (!resetn_sync) begin
      sclk_prev <= 1'b0;
      cs_prev <= 1'b1;
    end else begin
      sclk_prev <= sclk_sync;
      cs_prev <= cs_sync;
    end
  end

  // shift register: loaded at select, moved on each falling sclk
  always_ff @(posedge modulator_clock_in) begin
    if (!resetn_sync) begin
      shift <= '0;
    end else if (cs_prev && !cs_sync) begin
      shift <= frame; // snapshot keeps a set whole during the read
    end else if (!cs_sync && sclk_prev && !sclk_sync) begin
      shift <= {shift[FRAME_BITS-2:0], 1'b0};
    end
  end

  assign link.spi_miso = shift[FRAME_BITS-1];

  // count rising sclk edges of the current frame
  always_ff @(posedge modulator_clock_in) begin
    if (!resetn_sync) begin
      bit_count <= '0;
    end else if (cs_prev && !cs_sync) begin
      bit_count <= '0;
    end else if (!cs_sync && !sclk_prev && sclk_sync && bit_count != FRAME_LAST) begin
      bit_count <= bit_count + BW'(1);
    end
  end

  // a read counts only when all bits went out before select rose
  assign read_done = !cs_prev && cs_sync && (bit_count == FRAME_LAST);

  // sample-ready flag; a new set wins over a clear in the same cycle
  always_ff @(posedge modulator_clock_in) begin
    if (!resetn_sync) begin
      ready <= 1'b0;
    end else if (set_ready) begin
      ready <= 1'b1;
    end else if (read_done) begin
      ready <= 1'b0;
    end
  end

  assign link.sample_ready = ready;

endmodule // filter_device

// [rtl/host_end.sv]
// host end: modulator clock divider, link reset, conversion timer, spi reader
// assumes ssync_if joins it to the filter device and a 14-bit converter on the user side
`timescale 1ns/1ps
`include "ssync_defs.svh"
module host_end
  import ssync_pkg::*;
#(
  parameter int CHANNELS = `SS_CHANNELS,
  parameter int EFFECTIVE_OVERSAMPLING_RATIO = `SS_EFFECTIVE_OVERSAMPLING_RATIO,
  parameter int MOD_HALF = `SS_MOD_HALF,
  parameter int SPI_HALF = `SS_SPI_HALF
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // link to the filter device
  ssync_if.host link,
  // voltage converter result
  input wire logic [`SS_VOLT_W-1:0] i_voltage_sample,
  input wire logic i_voltage_done,
  // conversion trigger and results
  output logic o_voltage_convert_start,
  output volt_type o_voltage_sample,
  output logic o_voltage_valid,
  output logic [CHANNELS*`SS_SAMPLE_W-1:0] o_current_sample,
  output logic o_current_valid
);

  localparam int FRAME_BITS = CHANNELS * `SS_SAMPLE_W; // bits per read
  localparam int BW = $clog2(FRAME_BITS + 1); // bit counter width
  localparam int DW = (MOD_HALF > 1) ? $clog2(MOD_HALF) : 1; // divider width
  localparam int TW = $clog2(EFFECTIVE_OVERSAMPLING_RATIO); // timer width
  localparam int HW = $clog2(`SS_FRAME_GAP + 1); // wait counter width
  localparam logic [DW-1:0] DIV_LAST = DW'(MOD_HALF - 1);
  localparam logic [TW-1:0] TIMER_LAST = TW'(EFFECTIVE_OVERSAMPLING_RATIO - 1);
  localparam logic [HW-1:0] HALF_LAST = HW'(SPI_HALF - 1);
  localparam logic [HW-1:0] GAP_LAST = HW'(`SS_FRAME_GAP - 1);
  localparam logic [BW-1:0] BITS_LAST = BW'(FRAME_BITS - 1);
  localparam logic [4:0] LRST_LAST = 5'(`SS_LINK_RESET_TICKS - 1);

  logic [DW-1:0] div_count; // divider phase
  logic mod_clk; // modulator clock register
  logic mod_rise; // modulator clock rises next edge
  logic [4:0] lrst_count; // modulator ticks since reset
  logic link_rst_n; // link reset register
  logic [TW-1:0] timer; // conversion timer
  logic rdy_meta, rdy_sync; // sample-ready synchronizer stages
  logic miso_meta, miso_sync; // spi data synchronizer stages
  host_state_type state; // spi sequencer
  logic [HW-1:0] wait_count; // phase timer
  logic [BW-1:0] bit_idx; // bits taken so far
  logic [FRAME_BITS-1:0] rx; // incoming frame
  logic sclk; // spi clock register
  logic cs_n; // spi select register

  // modulator clock divided from the host clock, kept running in reset
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      div_count <= '0;
      mod_clk <= (mod_clk === 1'b0);
    end else if (div_count == DIV_LAST) begin
      div_count <= '0;
      mod_clk <= ~mod_clk;
    end else begin
      div_count <= div_count + DW'(1);
    end
  end

  assign mod_rise = (div_count == DIV_LAST) && !mod_clk;
  assign link.host_subsystem_clock_out = mod_clk;

  // link reset held low for a number of modulator ticks
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      lrst_count <= '0;
      link_rst_n <= 1'b0;
    end else if (mod_rise && !link_rst_n) begin
      lrst_count <= lrst_count + 5'(1);
      link_rst_n <= (lrst_count == LRST_LAST);
    end
  end

  assign link.link_resetn = link_rst_n;

  // timer counts modulator ticks up to the effective ratio
  always_ff @(posedge i_clk) begin
    if (!i_resetn || !link_rst_n) begin
      timer <= '0;
      o_voltage_convert_start <= 1'b0;
    end else begin
      o_voltage_convert_start <= mod_rise && (timer == TIMER_LAST);
      if (mod_rise) begin
        timer <= (timer == TIMER_LAST) ? '0 : timer + TW'(1);
      end
    end
  end

  // converter result capture
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_voltage_sample <= '0;
      o_voltage_valid <= 1'b0;
    end else begin
      o_voltage_valid <= i_voltage_done;
      if (i_voltage_done) begin
        o_voltage_sample <= i_voltage_sample;
      end
    end
  end

  // device pins pass two flops
  always_ff @(posedge i_clk) begin
    rdy_meta <= link.sample_ready;
    rdy_sync <= rdy_meta;
    miso_meta <= link.spi_miso;
    miso_sync <= miso_meta;
  end

  // spi read sequencer, started by sample-ready
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      state <= st_idle;
      wait_count <= '0;
      bit_idx <= '0;
      rx <= '0;
      sclk <= 1'b0;
      cs_n <= 1'b1;
      o_current_sample <= '0;
      o_current_valid <= 1'b0;
    end else begin
      o_current_valid <= 1'b0;
      case (state)
        st_idle: begin
          if (rdy_sync && link_rst_n) begin
            cs_n <= 1'b0;
            wait_count <= '0;
            bit_idx <= '0;
            state <= st_lead;
          end
        end
        st_lead, st_low: begin
          wait_count <= wait_count + HW'(1);
          if (wait_count == HALF_LAST) begin
            wait_count <= '0;
            sclk <= 1'b1;
            state <= st_high;
          end
        end
        st_high: begin
          wait_count <= wait_count + HW'(1);
          if (wait_count == HALF_LAST) begin
            wait_count <= '0;
            sclk <= 1'b0;
            rx <= {rx[FRAME_BITS-2:0], miso_sync};
            bit_idx <= bit_idx + BW'(1);
            if (bit_idx == BITS_LAST) begin
              cs_n <= 1'b1;
              o_current_sample <= {rx[FRAME_BITS-2:0], miso_sync};
              o_current_valid <= 1'b1;
              state <= st_gap;
            end else begin
              state <= st_low;
            end
          end
        end
        st_gap: begin
          wait_count <= wait_count + HW'(1);
          if (wait_count == GAP_LAST) begin
            wait_count <= '0;
            state <= st_idle;
          end
        end
        default: begin
          state <= st_idle;
        end
      endcase
    end
  end

  assign link.spi_sclk = sclk;
  assign link.spi_cs_n = cs_n;

endmodule // host_end

// [tb/ssync_properties.sv]
// concurrent checks on the link between the host end and the filter device end
// assumes the bench instantiates it beside ssync_if and passes the spi half period
`timescale 1ns/1ps
module ssync_properties #(
  parameter int EFFECTIVE_OVERSAMPLING_RATIO = 1024,
  parameter int SPI_HALF = 8
) (
  // host clock domain
  input wire logic i_clk,
  input wire logic i_resetn,
  // link signals
  input wire logic host_subsystem_clock_out,
  input wire logic link_resetn,
  input wire logic sample_ready,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_miso
);
  logic [15:0] low_cnt; // cycles with select low
  logic [7:0] edge_cnt; // sclk rises within one frame
  logic [7:0] since_rise; // cycles since select rose, saturating
  logic [15:0] tick; // modulator ticks since ready rose
  logic seen; // a first ready rise has passed

  // frame counters, cleared while deselected
  always_ff @(posedge i_clk) begin
    if (!i_resetn || spi_cs_n) begin
      low_cnt <= 16'h0000;
      edge_cnt <= 8'h00;
    end else begin
      low_cnt <= low_cnt + 16'h0001;
      if ($rose(spi_sclk)) begin
        edge_cnt <= edge_cnt + 8'h01;
      end
    end
  end

  // distance from the end of the last frame
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      since_rise <= 8'hff;
    end else if ($rose(spi_cs_n)) begin
      since_rise <= 8'h00;
    end else if (since_rise != 8'hff) begin
      since_rise <= since_rise + 8'h01;
    end
  end

  // ready period in modulator ticks; first rise only starts it
  always_ff @(posedge host_subsystem_clock_out) begin
    if (!link_resetn) begin
      tick <= 16'h0000;
      seen <= 1'b0;
    end else if ($rose(sample_ready)) begin
      tick <= 16'h0000;
      seen <= 1'b1;
    end else begin
      tick <= tick + 16'h0001;
    end
  end

  a_clk_divider: assert property (@(posedge i_clk) disable iff (!i_resetn)
    host_subsystem_clock_out != $past(host_subsystem_clock_out))
    else $error("modulator clock did not toggle");
  a_link_reset_hold: assert property (@(posedge i_clk) disable iff (!i_resetn)
    $rose(i_resetn) |-> !link_resetn [*8])
    else $error("device reset released too early");
  a_sclk_idle_low: assert property (@(posedge i_clk) disable iff (!i_resetn)
    spi_cs_n |-> !spi_sclk)
    else $error("sclk high while deselected");
  a_lead_time: assert property (@(posedge i_clk) disable iff (!i_resetn)
    $fell(spi_cs_n) |-> !spi_sclk [*8] ##1 spi_sclk)
    else $error("select lead time wrong");
  a_sclk_high_phase: assert property (@(posedge i_clk) disable iff (!i_resetn)
    $rose(spi_sclk) |-> spi_sclk [*8] ##1 !spi_sclk)
    else $error("sclk high phase wrong");
  a_read_on_ready: assert property (@(posedge i_clk) disable iff (!i_resetn)
    $fell(spi_cs_n) |-> sample_ready)
    else $error("read started without ready");
  a_frame_length: assert property (@(posedge i_clk) disable iff (!i_resetn)
    $rose(spi_cs_n) |-> low_cnt == 16'(150 * SPI_HALF) && edge_cnt == 8'd75)
    else $error("frame length or bit count wrong");
  a_ready_cleared: assert property (@(posedge i_clk) disable iff (!i_resetn)
    $fell(sample_ready) && link_resetn |-> since_rise < 8'd24)
    else $error("ready dropped without a finished read");
  a_ready_period: assert property (@(posedge host_subsystem_clock_out)
    disable iff (!link_resetn) $rose(sample_ready) && seen |-> tick == 16'(EFFECTIVE_OVERSAMPLING_RATIO - 1))
    else $error("ready period wrong");
  a_miso_steady: assert property (@(posedge i_clk) disable iff (!i_resetn)
    spi_sclk |-> $stable(spi_miso))
    else $error("miso moved in high phase");

  // main scenarios reached
  c_read_frame: cover property (@(posedge i_clk) disable iff (!i_resetn) $rose(spi_cs_n));
  c_ready_clear: cover property (@(posedge i_clk) disable iff (!i_resetn) $fell(sample_ready));
  c_ready_set: cover property (@(posedge host_subsystem_clock_out) $rose(sample_ready));
endmodule // ssync_properties

// [tb/shunt_sample_synchronizer_tb_top.sv]
// self-checking bench: host end and filter device end joined by ssync_if
// assumes rtl package, header, interface and both ends compiled first
`timescale 1ns/1ps
module shunt_sample_synchronizer_tb_top
  import ssync_pkg::*;
();
  localparam int FILTER_OSR = 128; // decimation per filter output
  localparam int INTEG_OSR = 8; // filter outputs per set
  localparam int EFFECTIVE_OVERSAMPLING_RATIO = FILTER_OSR * INTEG_OSR; // ticks per set
  localparam int SPI_HALF = 8; // short spi phases so a read fits one set
  localparam int SW = $bits(sample_type);
  localparam sample_type FULL = sample_type'(FILTER_OSR ** 3 * INTEG_OSR); // all-ones sum
  localparam sample_type ZERO = '0;
  localparam volt_type VOLTS [4] = '{14'h0000, 14'h3fff, 14'h2aaa, 14'h1555};

  logic i_clk; // host clock, 20 mhz
  logic i_resetn; // host reset, active low
  logic i_forward_enable; // clock forwarding configuration
  logic [2:0] i_bitstream; // modulator bits
  volt_type i_voltage_sample; // converter result
  logic i_voltage_done; // converter finished
  logic o_voltage_convert_start, o_voltage_valid, o_current_valid, o_clocks_running;
  volt_type o_voltage_sample;
  logic [3*SW-1:0] o_current_sample;
  logic [2:0] o_channel_clock_out;
  int num_errors = 0; // mismatches
  int check_count = 0; // comparisons

  ssync_if ssync_if_inst();
  host_end #(.CHANNELS(3), .EFFECTIVE_OVERSAMPLING_RATIO(EFFECTIVE_OVERSAMPLING_RATIO), .MOD_HALF(1), .SPI_HALF(SPI_HALF)) host_end_inst (
    .i_clk(i_clk), .i_resetn(i_resetn), .link(ssync_if_inst.host),
    .i_voltage_sample(i_voltage_sample), .i_voltage_done(i_voltage_done),
    .o_voltage_convert_start(o_voltage_convert_start), .o_voltage_sample(o_voltage_sample),
    .o_voltage_valid(o_voltage_valid), .o_current_sample(o_current_sample),
    .o_current_valid(o_current_valid));
  filter_device #(.CHANNELS(3), .FILTER_OSR(FILTER_OSR), .INTEG_OSR(INTEG_OSR))
    filter_device_inst (.link(ssync_if_inst.device), .i_forward_enable(i_forward_enable),
    .i_bitstream(i_bitstream), .o_channel_clock_out(o_channel_clock_out),
    .o_clocks_running(o_clocks_running));
  ssync_properties #(.EFFECTIVE_OVERSAMPLING_RATIO(EFFECTIVE_OVERSAMPLING_RATIO), .SPI_HALF(SPI_HALF)) ssync_properties_inst (
    .i_clk(i_clk), .i_resetn(i_resetn),
    .host_subsystem_clock_out(ssync_if_inst.host_subsystem_clock_out),
    .link_resetn(ssync_if_inst.link_resetn), .sample_ready(ssync_if_inst.sample_ready),
    .spi_sclk(ssync_if_inst.spi_sclk), .spi_cs_n(ssync_if_inst.spi_cs_n),
    .spi_miso(ssync_if_inst.spi_miso));

  // clock generator
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end

  // compare tasks, one per kind of result
  task automatic cmp_bit(input logic got, input logic exp, input string what);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask
  task automatic cmp_set(input logic [3*SW-1:0] got, input logic [3*SW-1:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t current set got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmp_volt(input volt_type got, input volt_type exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t voltage got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmp_count(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t %s got %0d exp %0d", $time, what, got, exp);
    end
  endtask

  // next finished read, bounded
  task automatic wait_valid();
    int n;
    n = 0;
    do begin
      @(negedge i_clk);
      n++;
    end while (o_current_valid !== 1'b1 && n < 3000);
    cmp_count(int'(n < 3000), 1, "read finished");
  endtask

  // five-cycle reset, then idle levels while link reset holds
  task automatic t_reset();
    @(negedge i_clk);
    i_resetn = 1'b0;
    repeat (5) @(negedge i_clk);
    i_resetn = 1'b1;
    repeat (10) @(negedge i_clk);
    cmp_bit(ssync_if_inst.link_resetn, 1'b0, "link reset");
    cmp_bit(ssync_if_inst.spi_cs_n, 1'b1, "select idle");
    cmp_bit(ssync_if_inst.sample_ready, 1'b0, "ready idle");
    cmp_bit(o_current_valid, 1'b0, "current valid idle");
    cmp_count(o_channel_clock_out, 0, "channel clocks in reset");
  endtask

  // channel clocks low until enabled, then follow the modulator clock
  task automatic t_forward();
    int n;
    repeat (20) @(negedge i_clk);
    cmp_count(o_channel_clock_out, 0, "clocks while disabled");
    cmp_bit(o_clocks_running, 1'b0, "running while disabled");
    i_forward_enable = 1'b1;
    n = 0;
    while (o_clocks_running !== 1'b1 && n < 40) begin
      @(negedge i_clk);
      n++;
    end
    cmp_bit(o_clocks_running, 1'b1, "running after enable");
    repeat (6) begin
      @(negedge i_clk);
      cmp_count(o_channel_clock_out,
        ssync_if_inst.host_subsystem_clock_out === 1'b1 ? 7 : 0, "forwarded clocks");
    end
  endtask

  // timer trigger, then back-to-back conversion results
  task automatic t_voltage();
    int n;
    n = 0;
    while (o_voltage_convert_start !== 1'b1 && n < 2200) begin
      @(negedge i_clk);
      n++;
    end
    cmp_bit(o_voltage_convert_start, 1'b1, "timer trigger");
    for (int k = 0; k < 4; k++) begin
      i_voltage_sample = VOLTS[k];
      i_voltage_done = 1'b1;
      @(negedge i_clk);
      cmp_bit(o_voltage_valid, 1'b1, "voltage valid");
      cmp_volt(o_voltage_sample, VOLTS[k]);
    end
    i_voltage_done = 1'b0;
    @(negedge i_clk);
    cmp_bit(o_voltage_valid, 1'b0, "voltage valid ends");
    cmp_volt(o_voltage_sample, VOLTS[3]);
  endtask

  // steady streams give full or zero sums; ready drops after read
  task automatic t_samples(input logic [2:0] bits, input logic [3*SW-1:0] exp);
    i_bitstream = bits;
    repeat (4) wait_valid();
    cmp_set(o_current_sample, exp);
    repeat (20) @(negedge i_clk);
    cmp_bit(ssync_if_inst.sample_ready, 1'b0, "ready after read");
  endtask

  // one timer trigger per sample set
  task automatic t_ratio();
    int starts;
    int n;
    wait_valid();
    repeat (3) begin
      starts = 0;
      n = 0;
      do begin
        @(negedge i_clk);
        n++;
        if (o_voltage_convert_start === 1'b1) starts++;
      end while (o_current_valid !== 1'b1 && n < 3000);
      cmp_count(starts, 1, "triggers per set");
    end
  endtask

  // verdict and end of run
  task automatic report_and_stop();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // main sequence, inputs change on falling edges
  initial begin
    i_resetn = 1'b0;
    i_forward_enable = 1'b0;
    i_bitstream = 3'h0;
    i_voltage_sample = 14'h0000;
    i_voltage_done = 1'b0;
    t_reset();
    t_forward();
    t_voltage();
    t_samples(3'h1, {FULL, ZERO, ZERO});
    t_samples(3'h6, {ZERO, FULL, FULL});
    t_ratio();
    t_reset();
    report_and_stop();
  end

  // hang guard, well beyond the expected run
  initial begin
    #(60000 * 50);
    num_errors++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    report_and_stop();
  end
endmodule // shunt_sample_synchronizer_tb_top
